// ==== host_port_regs.svh ====
// constants for the device-side parallel host port control logic
// assumes inclusion by bare name from the design file and the testbench
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// ------------------------------------------------------------
// task-file addresses (command block, 3-bit)
// ------------------------------------------------------------
`define ADDR_DATA 3'h0
`define ADDR_SELECT 3'h6
`define ADDR_STATUS_CMD 3'h7

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define DEVSEL_BIT 4
`define CTL_IRQ_OFF_BIT 1
`define CTL_SOFT_RST_BIT 2
`define CTL_RESET 8'h00
`define SELECT_RESET 8'h00

// ------------------------------------------------------------
// commands whose first block raises no interrupt
// ------------------------------------------------------------
`define CMD_FORMAT_TRACK 8'h50
`define CMD_WRITE_SECTOR 8'h30
`define CMD_WRITE_SECTOR_NR 8'h31
`define CMD_WRITE_BUFFER 8'hE8
`define CMD_WRITE_LONG 8'h32
`define CMD_WRITE_LONG_NR 8'h33

`endif

// ==== host_port_pkg.sv ====
// types shared by the host port control logic
// assumes a single system clock and synchronous host strobes
package host_port_pkg;
    // host-side access presented on the connector
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic cs_ctl_n;
        logic [2:0] addr;
        logic [15:0] wdata;
    } host_acc_s;

    // core-side register/data answer
    typedef struct packed {
        logic ready;
        logic [15:0] rdata;
    } core_ans_s;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_WAIT,
        ACC_DRIVE
    } acc_state_e;
endpackage

// ==== host_port_ctrl.sv ====
// device-side control of the parallel host port: strobes, ready, irq, dma
// assumes host pins are already synchronous to I_SYS_CLK
//
// Behaviour
// - during a read strobe while selected or dma granted, addressed register or data word drives the data bus
// - ready is driven low while the core cannot yet complete an access
// - ready is left undriven whenever no cycle is being stretched
// - cable select low makes this drive 0, high makes it drive 1
// - interrupt asserted only if pending, selected and irq-off bit clear
// - interrupt pin undriven when irq-off set or drive not selected
// - pending interrupt cleared by reset, soft reset, command write, status read
// - in pio mode an interrupt is raised at each data block start
// - first block of format, write sector, buffer, long raises no interrupt
// - dma request asserted whenever the core is ready to move data
`include "host_port_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module host_port_ctrl (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire host_port_pkg::host_acc_s I_HOST,
    input wire logic I_CABLE_SEL,
    input wire logic I_DMA_GRANT_N,
    input wire host_port_pkg::core_ans_s I_CORE,
    input wire logic I_CORE_IRQ,
    input wire logic I_BLOCK_START,
    input wire logic I_DMA_READY,
    output logic [15:0] O_DATA,
    output logic O_DATA_OE_N,
    output logic O_IORDY,
    output logic O_IORDY_OE_N,
    output logic O_INTRQ,
    output logic O_INTRQ_OE_N,
    output logic O_DMARQ,
    output logic O_IS_DRIVE1,
    output logic O_CORE_STB,
    output logic O_CORE_WRITE,
    output logic [2:0] O_CORE_ADDR,
    output logic [15:0] O_CORE_WDATA
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    host_port_pkg::acc_state_e state, next_state;
    logic [7:0] ctl, next_ctl;
    logic [7:0] select, next_select;
    logic pending, next_pending;
    logic first_skip, next_first_skip;
    logic rd_q, next_rd_q;
    logic wr_q, next_wr_q;
    logic [15:0] data, next_data;
    logic data_oe_n, next_data_oe_n;
    logic iordy_oe_n, next_iordy_oe_n;
    logic intrq_oe_n, next_intrq_oe_n;
    logic dmarq, next_dmarq;
    logic drive1, next_drive1;
    logic core_stb, next_core_stb;
    logic core_write, next_core_write;
    logic [2:0] core_addr, next_core_addr;
    logic [15:0] core_wdata, next_core_wdata;

    // commands that suppress the first-block interrupt
    function automatic logic skips_first(input logic [7:0] cmd);
        case (cmd)
            `CMD_FORMAT_TRACK, `CMD_WRITE_SECTOR, `CMD_WRITE_SECTOR_NR,
            `CMD_WRITE_BUFFER, `CMD_WRITE_LONG, `CMD_WRITE_LONG_NR: skips_first = 1'b1;
            default: skips_first = 1'b0;
        endcase
    endfunction

    // status/command register decode, used for reads and writes alike
    function automatic logic is_cmd_reg(input host_port_pkg::host_acc_s h);
        is_cmd_reg = h.cs_ctl_n && (h.addr == `ADDR_STATUS_CMD);
    endfunction

    logic rd_act, wr_act, rd_rise, wr_rise, rd_fall, wr_fall, selected;
    assign rd_act = ~I_HOST.rd_n;
    assign wr_act = ~I_HOST.wr_n;
    assign rd_fall = rd_act & ~rd_q;
    assign wr_fall = wr_act & ~wr_q;
    assign rd_rise = ~rd_act & rd_q;
    assign wr_rise = ~wr_act & wr_q;
    // drive-select bit compared with own role
    assign selected = (select[`DEVSEL_BIT] == drive1);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_ctl = ctl;
        next_select = select;
        next_pending = pending;
        next_first_skip = first_skip;
        next_rd_q = rd_act;
        next_wr_q = wr_act;
        next_data = data;
        next_data_oe_n = data_oe_n;
        next_iordy_oe_n = 1'b1;
        next_dmarq = I_DMA_READY;
        next_drive1 = I_CABLE_SEL;
        next_core_stb = 1'b0;
        next_core_write = core_write;
        next_core_addr = core_addr;
        next_core_wdata = core_wdata;
        // access sequencing: request core, stretch until answer
        case (state)
            host_port_pkg::ACC_IDLE: begin
                if ((rd_fall || wr_fall) && (selected || !I_DMA_GRANT_N)) begin
                    next_core_stb = 1'b1;
                    next_core_write = wr_fall;
                    next_core_addr = I_HOST.addr;
                    next_core_wdata = I_HOST.wdata;
                    next_state = host_port_pkg::ACC_WAIT;
                    next_iordy_oe_n = 1'b0;
                end
            end
            host_port_pkg::ACC_WAIT: begin
                if (I_CORE.ready) begin
                    next_data = I_CORE.rdata;
                    // only a read turns the bus round; a write leaves it released
                    next_data_oe_n = core_write;
                    next_state = host_port_pkg::ACC_DRIVE;
                end else begin
                    next_iordy_oe_n = 1'b0;
                end
            end
            host_port_pkg::ACC_DRIVE: begin
                // data stays on the bus until the strobe rises
                if (rd_rise || wr_rise || (!rd_act && !wr_act)) begin
                    next_data_oe_n = 1'b1;
                    next_state = host_port_pkg::ACC_IDLE;
                end
            end
            default: next_state = host_port_pkg::ACC_IDLE;
        endcase
        // register side effects on strobe completion
        if (wr_rise && !I_HOST.cs_ctl_n) begin
            next_ctl = I_HOST.wdata[7:0];
        end
        if (wr_rise && I_HOST.cs_ctl_n && I_HOST.addr == `ADDR_SELECT) begin
            next_select = I_HOST.wdata[7:0];
        end
        // interrupt source: core event or pio block start, minus first-block skip
        if (I_CORE_IRQ || (I_BLOCK_START && !first_skip)) begin
            next_pending = 1'b1;
        end
        if (I_BLOCK_START && first_skip) begin
            next_first_skip = 1'b0;
        end
        // clears take priority here: a host reading status or writing a command has seen it
        if ((wr_rise && is_cmd_reg(I_HOST)) || (rd_fall && is_cmd_reg(I_HOST))
            || next_ctl[`CTL_SOFT_RST_BIT]) begin
            next_pending = 1'b0;
        end
        if (wr_rise && is_cmd_reg(I_HOST)) begin
            next_first_skip = skips_first(I_HOST.wdata[7:0]);
        end
        // output undriven unless all three conditions hold
        next_intrq_oe_n = ~(next_pending && selected
            && !next_ctl[`CTL_IRQ_OFF_BIT]);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            state <= host_port_pkg::ACC_IDLE;
            ctl <= `CTL_RESET;
            select <= `SELECT_RESET;
            pending <= 1'b0;
            first_skip <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            data <= 16'h0000;
            data_oe_n <= 1'b1;
            iordy_oe_n <= 1'b1;
            intrq_oe_n <= 1'b1;
            dmarq <= 1'b0;
            drive1 <= 1'b0;
            core_stb <= 1'b0;
            core_write <= 1'b0;
            core_addr <= 3'h0;
            core_wdata <= 16'h0000;
        end else begin
            state <= next_state;
            ctl <= next_ctl;
            select <= next_select;
            pending <= next_pending;
            first_skip <= next_first_skip;
            rd_q <= next_rd_q;
            wr_q <= next_wr_q;
            data <= next_data;
            data_oe_n <= next_data_oe_n;
            iordy_oe_n <= next_iordy_oe_n;
            intrq_oe_n <= next_intrq_oe_n;
            dmarq <= next_dmarq;
            drive1 <= next_drive1;
            core_stb <= next_core_stb;
            core_write <= next_core_write;
            core_addr <= next_core_addr;
            core_wdata <= next_core_wdata;
        end
    end

    // ------------------------------------------------------------
    // outputs, each straight from a flop except the constant ready and interrupt levels
    // ------------------------------------------------------------
    assign O_DATA = data;
    assign O_DATA_OE_N = data_oe_n;
    assign O_IORDY = 1'b0;           // only ever driven low
    assign O_IORDY_OE_N = iordy_oe_n;
    assign O_INTRQ = 1'b1;           // active high when enabled
    assign O_INTRQ_OE_N = intrq_oe_n;
    assign O_DMARQ = dmarq;
    assign O_IS_DRIVE1 = drive1;
    assign O_CORE_STB = core_stb;
    assign O_CORE_WRITE = core_write;
    assign O_CORE_ADDR = core_addr;
    assign O_CORE_WDATA = core_wdata;
endmodule // host_port_ctrl

`default_nettype wire

// ==== host_port_ctrl_props.sv ====
// assertions on the host port control block, bound to its top ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module host_port_ctrl_props (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire host_port_pkg::host_acc_s I_HOST,
    input wire logic I_CABLE_SEL,
    input wire logic I_DMA_GRANT_N,
    input wire host_port_pkg::core_ans_s I_CORE,
    input wire logic I_DMA_READY,
    input wire logic [15:0] O_DATA,
    input wire logic O_DATA_OE_N,
    input wire logic O_IORDY_OE_N,
    input wire logic O_INTRQ_OE_N,
    input wire logic O_DMARQ,
    input wire logic O_IS_DRIVE1,
    input wire logic O_CORE_STB,
    input wire logic O_CORE_WRITE
);
    default clocking dc @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    // reset leaves the ready, interrupt and data pins released; checked even while reset holds
    property p_rst_idle;
        disable iff (1'b0) $past(I_SYS_RST) |-> O_IORDY_OE_N && O_INTRQ_OE_N && O_DATA_OE_N;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pins driven after reset");
    property p_dmarq;
        !$past(I_SYS_RST) |-> O_DMARQ == $past(I_DMA_READY);
    endproperty
    a_dmarq: assert property (p_dmarq) else $error("dma request lag wrong");
    property p_role;
        !$past(I_SYS_RST) |-> O_IS_DRIVE1 == $past(I_CABLE_SEL);
    endproperty
    a_role: assert property (p_role) else $error("drive role wrong");
    property p_stretch;
        O_CORE_STB |-> !O_IORDY_OE_N;
    endproperty
    a_stretch: assert property (p_stretch) else $error("ready not held low");
    property p_release;
        !O_IORDY_OE_N && I_CORE.ready |=> O_IORDY_OE_N;
    endproperty
    a_release: assert property (p_release) else $error("ready not released");
    // a granted read strobe from idle must reach the core next cycle
    property p_take;
        $fell(I_HOST.rd_n) && I_HOST.wr_n && !I_DMA_GRANT_N && O_IORDY_OE_N && O_DATA_OE_N
            |=> O_CORE_STB && !O_CORE_WRITE;
    endproperty
    a_take: assert property (p_take) else $error("granted read not taken");
    property p_rdata;
        $fell(O_DATA_OE_N) |-> O_DATA == $past(I_CORE.rdata);
    endproperty
    a_rdata: assert property (p_rdata) else $error("wrong read word");
    property p_data_end;
        !O_DATA_OE_N && I_HOST.rd_n |=> O_DATA_OE_N;
    endproperty
    a_data_end: assert property (p_data_end) else $error("bus held after strobe");
endmodule // host_port_ctrl_props
bind host_port_ctrl host_port_ctrl_props i_host_port_ctrl_props (.I_SYS_CLK, .I_SYS_RST,
    .I_HOST, .I_CABLE_SEL, .I_DMA_GRANT_N, .I_CORE, .I_DMA_READY, .O_DATA, .O_DATA_OE_N,
    .O_IORDY_OE_N, .O_INTRQ_OE_N, .O_DMARQ, .O_IS_DRIVE1, .O_CORE_STB, .O_CORE_WRITE);
`default_nettype wire

// ==== host_model.sv ====
// host adapter model: drives strobes and address, reads the data bus
// assumes it shares the device clock and drives at the falling edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic i_clk,
    input wire logic [15:0] i_data,
    input wire logic i_data_oe_n,
    input wire logic i_iordy,
    input wire logic i_iordy_oe_n,
    output var host_port_pkg::host_acc_s o_host
);
    logic rdy;
    logic [15:0] bus;
    // released ready is pulled up; a released bus shows the inverse word
    assign rdy = i_iordy_oe_n ? 1'b1 : i_iordy;
    assign bus = i_data_oe_n ? ~i_data : i_data;
    initial o_host = '{rd_n: 1'b1, wr_n: 1'b1, cs_ctl_n: 1'b1, addr: 3'h0, wdata: 16'h0};
    // one access; strobe held while ready is low, word taken as it rises
    task automatic access(input logic rd, input logic ctl, input logic [2:0] a,
        input logic [15:0] wd, output logic [15:0] q, output int waits);
        @(negedge i_clk);
        o_host = '{rd_n: !rd, wr_n: rd, cs_ctl_n: !ctl, addr: a, wdata: wd};
        repeat (2) @(negedge i_clk);
        waits = 0;
        while (!rdy && waits < 64) begin
            @(negedge i_clk);
            waits++;
        end
        @(negedge i_clk);
        q = bus;
        o_host.rd_n = 1'b1;
        o_host.wr_n = 1'b1;
        repeat (2) @(negedge i_clk);
    endtask
endmodule // host_model
`default_nettype wire

// ==== test_host_port_ctrl.sv ====
// self-checking bench for the host port control block
// assumes host_model as the host and a small core responder here
`include "host_port_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module test_host_port_ctrl;
    logic sys_clk = 1'b0, sys_rst = 1'b1, cable_sel = 1'b0, grant_n = 1'b1;
    logic core_irq = 1'b0, blk = 1'b0, dma_rdy = 1'b0;
    host_port_pkg::host_acc_s host;
    logic core_ready = 1'b0;
    logic [15:0] core_rdata = 16'h0000;
    host_port_pkg::core_ans_s core;
    logic core_wr, wr_seen;
    logic [2:0] core_addr, addr_seen;
    logic [15:0] core_wd, wd_seen;
    // one driver per field: the responder owns ready, the sequence owns the word
    assign core = {core_ready, core_rdata};
    logic [15:0] data, q;
    logic data_oe_n, iordy, iordy_oe_n, intrq, intrq_oe_n, dmarq, is_d1, stb;
    int fails = 0, checked = 0, dly = 1, cnt = 0, stbs = 0, w, n;
    typedef struct { logic ctl; logic [2:0] a; logic [15:0] v; int d; } row_s;
    row_s rows[4] = '{'{1'b0, 3'h0, 16'h1234, 1}, '{1'b0, 3'h3, 16'hA55A, 6},
        '{1'b1, 3'h6, 16'h00C3, 2}, '{1'b0, 3'h5, 16'hFFFF, 3}};
    logic [7:0] skip[6] = '{`CMD_FORMAT_TRACK, `CMD_WRITE_SECTOR, `CMD_WRITE_SECTOR_NR,
        `CMD_WRITE_BUFFER, `CMD_WRITE_LONG, `CMD_WRITE_LONG_NR};
    host_port_ctrl i_host_port_ctrl (.I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst), .I_HOST(host),
        .I_CABLE_SEL(cable_sel), .I_DMA_GRANT_N(grant_n), .I_CORE(core), .I_CORE_IRQ(core_irq),
        .I_BLOCK_START(blk), .I_DMA_READY(dma_rdy), .O_DATA(data), .O_DATA_OE_N(data_oe_n),
        .O_IORDY(iordy), .O_IORDY_OE_N(iordy_oe_n), .O_INTRQ(intrq), .O_INTRQ_OE_N(intrq_oe_n),
        .O_DMARQ(dmarq), .O_IS_DRIVE1(is_d1), .O_CORE_STB(stb), .O_CORE_WRITE(core_wr),
        .O_CORE_ADDR(core_addr), .O_CORE_WDATA(core_wd));
    host_model i_host_model (.i_clk(sys_clk), .i_data(data), .i_data_oe_n(data_oe_n),
        .i_iordy(iordy), .i_iordy_oe_n(iordy_oe_n), .o_host(host));
    always #4 sys_clk = ~sys_clk;
    // core answers each strobe after dly cycles, so stretch length varies
    always @(negedge sys_clk) begin
        core_ready <= (cnt == 1);
        if (cnt != 0) begin
            cnt <= cnt - 1;
        end else if (stb === 1'b1) begin
            cnt <= dly;
            stbs <= stbs + 1;
            wr_seen <= core_wr;
            addr_seen <= core_addr;
            wd_seen <= core_wd;
        end
    end
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t word %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic acc(input logic rd, input logic ctl, input logic [2:0] a, input logic [15:0] v);
        i_host_model.access(rd, ctl, a, v, q, w);
        cmp1(w < 64, 1'b1);
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic test_done;
        $display("TB: checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        foreach (rows[k]) begin
            dly = rows[k].d;
            core_rdata = rows[k].v;
            acc(1'b1, rows[k].ctl, rows[k].a, 16'h0);
            cmp16(q, rows[k].v);
            cmp1(w == dly, 1'b1);
            cmp16({13'h0000, addr_seen}, {13'h0000, rows[k].a});
            cmp1(wr_seen, 1'b0);
        end
        // ready and interrupt pins only ever drive one level
        cmp1(iordy, 1'b0);
        cmp1(intrq, 1'b1);
        // drive 1 role while select names drive 0: strobes ignored unless dma is granted
        cable_sel = 1'b1;
        n = stbs;
        acc(1'b1, 1'b0, 3'h0, 16'h0);
        cmp1(is_d1, 1'b1);
        cmp1(stbs == n && w == 0, 1'b1);
        grant_n = 1'b0;
        core_rdata = 16'h5AA5;
        acc(1'b1, 1'b0, 3'h0, 16'h0);
        cmp16(q, 16'h5AA5);
        grant_n = 1'b1;
        pulse(core_irq);
        cmp1(intrq_oe_n, 1'b1);
        cable_sel = 1'b0;
        repeat (2) @(negedge sys_clk);
        cmp1(intrq_oe_n, 1'b0);
        acc(1'b0, 1'b1, 3'h6, 16'h0002);
        cmp1(intrq_oe_n, 1'b1);
        acc(1'b0, 1'b1, 3'h6, 16'h0000);
        cmp1(intrq_oe_n, 1'b0);
        acc(1'b1, 1'b0, `ADDR_STATUS_CMD, 16'h0);
        cmp1(intrq_oe_n, 1'b1);
        pulse(core_irq);
        acc(1'b0, 1'b1, 3'h6, 16'h0004);
        cmp1(intrq_oe_n, 1'b1);
        acc(1'b0, 1'b1, 3'h6, 16'h0000);
        pulse(core_irq);
        acc(1'b0, 1'b0, `ADDR_STATUS_CMD, 16'h0020);
        cmp1(intrq_oe_n, 1'b1);
        cmp16(wd_seen, 16'h0020);
        cmp1(wr_seen, 1'b1);
        // an ordinary command keeps its first-block interrupt
        pulse(blk);
        cmp1(intrq_oe_n, 1'b0);
        foreach (skip[k]) begin
            acc(1'b0, 1'b0, `ADDR_STATUS_CMD, {8'h00, skip[k]});
            pulse(blk);
            cmp1(intrq_oe_n, 1'b1);
            pulse(blk);
            cmp1(intrq_oe_n, 1'b0);
            acc(1'b1, 1'b0, `ADDR_STATUS_CMD, 16'h0);
        end
        // reset in mid-run with an interrupt pending
        pulse(core_irq);
        sys_rst = 1'b1;
        dma_rdy = 1'b1;
        repeat (2) @(negedge sys_clk);
        cmp1(intrq_oe_n, 1'b1);
        sys_rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        cmp1(dmarq, 1'b1);
        cmp1(intrq_oe_n, 1'b1);
        test_done;
    end
    // watchdog: the sequence needs well under a tenth of this span
    initial begin
        #100000;
        fails++;
        test_done;
    end
endmodule // test_host_port_ctrl
`default_nettype wire
